//--- design/comm_activity_watchdog_pkg.sv
/*
 * Shared constants for the communication activity watchdog.
 * Assumes a 100 MHz system clock and a one-second timebase built from it.
 */
package comm_activity_watchdog_pkg;
    localparam int          CLK_HZ             = 100_000_000;
    localparam int          TICK_SEC           = 1;
    localparam int          CYCLES_PER_SEC     = CLK_HZ * TICK_SEC;
    localparam int          TIMEOUT_W          = 12;
    localparam logic [11:0] TIMEOUT_MIN        = 12'h001;
    localparam logic [11:0] TIMEOUT_MAX        = 12'he10;
    localparam logic [11:0] TIMEOUT_RST        = 12'h001;
    localparam logic [11:0] STEP_COARSE        = 12'h00a;
    localparam logic [11:0] STEP_FINE          = 12'h001;
    localparam int          BLINK_HALF_SEC     = 1;
    localparam logic [15:0] ERR_CODE_TIMEOUT   = 16'h0156;
    localparam int          FAULT_BIT_POS      = 15;
    localparam int          FAULT_REG_W        = 16;
    localparam int          IF_SEL_W           = 2;
    localparam int          ADDR_W             = 8;

    typedef enum logic [1:0] {
        WD_IDLE    = 2'b00,
        WD_ARMED   = 2'b01,
        WD_RUNNING = 2'b10,
        WD_FAULT   = 2'b11
    } wd_state_type;
endpackage

//--- design/sync_stage.sv
/*
 * Three-flop synchroniser with agreement filter for one external level.
 * Assumes the input is asynchronous to clk; output changes only when
 * the second and third flops agree.
 */
`timescale 1ns/10ps
module sync_stage (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Level in and filtered level out
    input  wire logic async_in,
    output logic      level_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_out <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            level_out <= s3_ff;
        end
    end
endmodule

//--- design/comm_activity_watchdog.sv
/*
 * Communication activity watchdog: counts seconds since the last command
 * on the selected host interface and trips the output off on expiry.
 * Assumes command strobes come from same-clock parser logic; front-panel
 * buttons arrive asynchronously and are synchronised here.
 */
`timescale 1ns/10ps
//
// Function
// - Output off after timeout without activity
// - Enable via host command or panel
// - Timeout 1 to 3600 s, reject others
// - Timing starts at first command after enable
// - Interface change halts until next command
// - New timeout halts until next command
// - Expiry: output off, fault shown, blink
// - Expiry queues error 342 with address
// - Expiry sets fault register bit 15
// - Fault latched until clear or power cycle
// - Panel output button blocked during fault
// - Disabling watchdog clears latched fault
// - Web server traffic is not activity
// - Active only with standard command language
// - Panel steps 10 s coarse, 1 s fine
// - Panel up/down steps halt until next command
// - Fault bit follows live fault state
module comm_activity_watchdog #(
    parameter int CYCLES_PER_TICK = comm_activity_watchdog_pkg::CYCLES_PER_SEC
) (
    // Clock and reset
    input  wire logic                                               clk,
    input  wire logic                                               rst_b,
    // Host command side
    input  wire logic                                               cmd_rx_stb,
    input  wire logic [comm_activity_watchdog_pkg::IF_SEL_W-1:0]    cmd_rx_if,
    input  wire logic                                               cmd_rx_web,
    input  wire logic                                               host_wd_en_stb,
    input  wire logic                                               host_wd_en_val,
    input  wire logic                                               host_tmo_stb,
    input  wire logic [comm_activity_watchdog_pkg::TIMEOUT_W-1:0]   host_tmo_val,
    input  wire logic                                               host_prot_clear,
    // Configuration
    input  wire logic [comm_activity_watchdog_pkg::IF_SEL_W-1:0]    if_select,
    input  wire logic                                               legacy_command_language,
    input  wire logic [comm_activity_watchdog_pkg::ADDR_W-1:0]      unit_address,
    // Front panel, asynchronous
    input  wire logic                                               panel_wd_toggle,
    input  wire logic                                               panel_fine_btn,
    input  wire logic                                               panel_up_btn,
    input  wire logic                                               panel_down_btn,
    input  wire logic                                               panel_out_btn,
    input  wire logic                                               power_switch_on,
    // Output control and indication
    output logic                                                    output_on,
    output logic                                                    comms_timeout_fault,
    output logic                                                    alarm_led,
    output logic [comm_activity_watchdog_pkg::FAULT_REG_W-1:0]      fault_cond,
    output logic                                                    fine_mode,
    output logic                                                    wd_enabled,
    output logic [comm_activity_watchdog_pkg::TIMEOUT_W-1:0]        watchdog_timeout_value,
    output logic [comm_activity_watchdog_pkg::TIMEOUT_W-1:0]        seconds_left,
    output logic                                                    tmo_reject,
    // Error queue push
    output logic                                                    err_push,
    output logic [15:0]                                             err_code,
    output logic [comm_activity_watchdog_pkg::ADDR_W-1:0]           err_addr
);
    import comm_activity_watchdog_pkg::*;

    localparam int TICK_CW = $clog2(CYCLES_PER_TICK + 1);

    // Synchronised front-panel levels and their rising edges
    logic [5:0] pan_raw;
    logic [5:0] pan_lvl;
    logic [5:0] pan_prev_ff;
    logic [5:0] pan_rise;

    assign pan_raw = {power_switch_on, panel_out_btn, panel_down_btn,
                      panel_up_btn, panel_fine_btn, panel_wd_toggle};

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_sync
            sync_stage u_sync (
                .clk       (clk),
                .rst_b     (rst_b),
                .async_in  (pan_raw[g]),
                .level_out (pan_lvl[g])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pan_prev_ff <= 6'h00;
        end else begin
            pan_prev_ff <= pan_lvl;
        end
    end

    assign pan_rise = pan_lvl & ~pan_prev_ff;

    logic pwr_off_edge;
    assign pwr_off_edge = ~pan_lvl[5] & pan_prev_ff[5];

    function automatic logic tmo_in_range(input logic [TIMEOUT_W-1:0] v);
        tmo_in_range = (v >= TIMEOUT_MIN) && (v <= TIMEOUT_MAX);
    endfunction

    // One-second tick divider
    logic [TICK_CW-1:0] tick_cnt_ff;
    logic               tick;

    assign tick = (tick_cnt_ff == TICK_CW'(CYCLES_PER_TICK - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_ff <= '0;
        end else if (tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + TICK_CW'(1);
        end
    end

    // Activity and configuration events
    logic activity;
    logic if_changed;
    logic [IF_SEL_W-1:0] if_sel_ff;
    logic lang_ok;

    assign lang_ok = ~legacy_command_language;
    assign activity = cmd_rx_stb & ~cmd_rx_web & (cmd_rx_if == if_select) & lang_ok;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            if_sel_ff <= '0;
        end else begin
            if_sel_ff <= if_select;
        end
    end

    assign if_changed = (if_sel_ff != if_select);

    // Enable state: host write or panel toggle
    logic nxt_wd_en;
    logic disable_evt;

    always_comb begin
        nxt_wd_en = wd_enabled;
        if (host_wd_en_stb) begin
            nxt_wd_en = host_wd_en_val;
        end else if (pan_rise[0]) begin
            nxt_wd_en = ~wd_enabled;
        end
    end

    assign disable_evt = wd_enabled & ~nxt_wd_en;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_enabled <= 1'b0;
        end else begin
            wd_enabled <= nxt_wd_en;
        end
    end

    // Timeout value: host write or panel step
    logic [TIMEOUT_W-1:0] step;
    logic [TIMEOUT_W:0]   up_sum;
    logic [TIMEOUT_W-1:0] nxt_tmo;
    logic                 tmo_written;

    assign step = fine_mode ? STEP_FINE : STEP_COARSE;
    assign up_sum = {1'b0, watchdog_timeout_value} + {1'b0, step};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fine_mode <= 1'b0;
        end else if (pan_rise[1]) begin
            fine_mode <= ~fine_mode;
        end
    end

    always_comb begin
        nxt_tmo     = watchdog_timeout_value;
        tmo_written = 1'b0;
        if (host_tmo_stb && tmo_in_range(host_tmo_val)) begin
            nxt_tmo     = host_tmo_val;
            tmo_written = 1'b1;
        end else if (pan_rise[2]) begin
            nxt_tmo     = (up_sum > {1'b0, TIMEOUT_MAX}) ? TIMEOUT_MAX : up_sum[TIMEOUT_W-1:0];
            tmo_written = 1'b1;
        end else if (pan_rise[3]) begin
            nxt_tmo     = (watchdog_timeout_value <= step) ? TIMEOUT_MIN
                                                           : watchdog_timeout_value - step;
            tmo_written = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_timeout_value <= TIMEOUT_RST;
            tmo_reject             <= 1'b0;
        end else begin
            watchdog_timeout_value <= nxt_tmo;
            tmo_reject             <= host_tmo_stb & ~tmo_in_range(host_tmo_val);
        end
    end

    // Fault clear sources
    logic fault_clear;
    assign fault_clear = host_prot_clear | pwr_off_edge | disable_evt;

    // Watchdog state machine
    wd_state_type state_ff;
    wd_state_type nxt_state;
    logic         expire;

    always_comb begin
        nxt_state = state_ff;
        expire    = 1'b0;
        case (state_ff)
            WD_IDLE: begin
                if (nxt_wd_en && lang_ok) begin
                    nxt_state = WD_ARMED;
                end
            end
            WD_ARMED: begin
                if (!nxt_wd_en || !lang_ok) begin
                    nxt_state = WD_IDLE;
                end else if (activity && !if_changed && !tmo_written) begin
                    nxt_state = WD_RUNNING;
                end
            end
            WD_RUNNING: begin
                if (!nxt_wd_en || !lang_ok) begin
                    nxt_state = WD_IDLE;
                end else if (if_changed || tmo_written) begin
                    nxt_state = WD_ARMED;
                end else if (!activity && tick && seconds_left == TIMEOUT_MIN) begin
                    nxt_state = WD_FAULT;
                    expire    = 1'b1;
                end
            end
            WD_FAULT: begin
                if (!nxt_wd_en || !lang_ok) begin
                    nxt_state = WD_IDLE;
                end else if (fault_clear) begin
                    nxt_state = WD_ARMED;
                end
            end
            default: begin
                nxt_state = WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= WD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // reload on command, count down on tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seconds_left <= '0;
        end else if (nxt_state == WD_RUNNING && activity) begin
            seconds_left <= nxt_tmo;
        end else if (state_ff == WD_RUNNING && tick && seconds_left != '0) begin
            seconds_left <= seconds_left - TIMEOUT_W'(1);
        end else if (nxt_state != WD_RUNNING) begin
            seconds_left <= '0;
        end
    end

    assign comms_timeout_fault = (state_ff == WD_FAULT);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_cond <= '0;
        end else begin
            fault_cond                <= '0;
            fault_cond[FAULT_BIT_POS] <= (nxt_state == WD_FAULT);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            err_push <= 1'b0;
            err_code <= 16'h0000;
            err_addr <= '0;
        end else begin
            err_push <= expire;
            if (expire) begin
                err_code <= ERR_CODE_TIMEOUT;
                err_addr <= unit_address;
            end
        end
    end

    // output control; panel cannot restore during fault
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            output_on <= 1'b0;
        end else if (expire || nxt_state == WD_FAULT) begin
            output_on <= 1'b0;
        end else if (pan_rise[4]) begin
            output_on <= ~output_on;
        end
    end

    // half-hertz alarm blink: one second on, one off
    logic [1:0] blink_sec_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_led    <= 1'b0;
            blink_sec_ff <= 2'h0;
        end else if (state_ff != WD_FAULT) begin
            // Light at once on expiry so the first on-phase is a full second
            alarm_led    <= expire;
            blink_sec_ff <= 2'h0;
        end else if (tick) begin
            if (blink_sec_ff == 2'(BLINK_HALF_SEC - 1)) begin
                blink_sec_ff <= 2'h0;
                alarm_led    <= ~alarm_led;
            end else begin
                blink_sec_ff <= blink_sec_ff + 2'h1;
            end
        end
    end
endmodule

//--- test/comm_activity_watchdog_assertions.sv
/*
 * Checker for the communication activity watchdog ports.
 * Assumes it is bound to the top module and sees its ports unchanged.
 */
`timescale 1ns/10ps
module comm_activity_watchdog_assertions
    import comm_activity_watchdog_pkg::*;
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst_b,
    // Host side
    input wire logic                 cmd_rx_stb,
    input wire logic [IF_SEL_W-1:0]  cmd_rx_if,
    input wire logic                 cmd_rx_web,
    input wire logic                 host_wd_en_stb,
    input wire logic                 host_wd_en_val,
    input wire logic                 host_tmo_stb,
    input wire logic [TIMEOUT_W-1:0] host_tmo_val,
    input wire logic                 host_prot_clear,
    input wire logic [IF_SEL_W-1:0]  if_select,
    input wire logic                 legacy_command_language,
    input wire logic [ADDR_W-1:0]    unit_address,
    // Outputs watched
    input wire logic                 output_on,
    input wire logic                 comms_timeout_fault,
    input wire logic [15:0]          fault_cond,
    input wire logic                 wd_enabled,
    input wire logic [TIMEOUT_W-1:0] watchdog_timeout_value,
    input wire logic [TIMEOUT_W-1:0] seconds_left,
    input wire logic                 tmo_reject,
    input wire logic                 err_push,
    input wire logic [15:0]          err_code,
    input wire logic [ADDR_W-1:0]    err_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic tmo_bad;
    assign tmo_bad = host_tmo_val == 12'h000 || host_tmo_val > 12'he10;

    AST_ERR_ENTRY: assert property (err_push |-> err_code == 16'h0156 && err_addr == unit_address)
        else $error("error entry code or address wrong");
    AST_EXPIRY: assert property ($rose(comms_timeout_fault) |-> err_push && !output_on && fault_cond[15])
        else $error("expiry did not push, shut output or set fault bit");
    AST_PUSH_ONCE: assert property (err_push == $rose(comms_timeout_fault))
        else $error("error push not tied to fault onset");
    AST_FAULT_BIT: assert property (fault_cond == {comms_timeout_fault, 15'h0000})
        else $error("fault register does not follow fault");
    AST_NO_OUTPUT: assert property (comms_timeout_fault |-> !output_on)
        else $error("output on during fault");
    AST_CLEAR: assert property (comms_timeout_fault && host_prot_clear |=> !comms_timeout_fault)
        else $error("clear command kept the fault");
    AST_DISABLE: assert property (host_wd_en_stb && !host_wd_en_val |=> !wd_enabled && !comms_timeout_fault)
        else $error("disable kept watchdog or fault");
    AST_REJECT: assert property (host_tmo_stb && tmo_bad |=> $stable(watchdog_timeout_value) ##[0:1] tmo_reject)
        else $error("out of range timeout not refused");
    AST_ACCEPT: assert property (host_tmo_stb && !tmo_bad |=> ##1 watchdog_timeout_value == $past(host_tmo_val, 2)
        && seconds_left == 12'h000)
        else $error("timeout write not taken or timer not halted");
    AST_RELOAD: assert property (cmd_rx_stb && !cmd_rx_web && cmd_rx_if == if_select && !legacy_command_language
        && wd_enabled && !comms_timeout_fault && !host_tmo_stb && !host_wd_en_stb && $stable(if_select)
        |=> seconds_left == watchdog_timeout_value)
        else $error("command did not reload countdown");
    AST_WEB: assert property (cmd_rx_stb && cmd_rx_web && seconds_left == 12'h000 |=> seconds_left == 12'h000)
        else $error("web traffic started countdown");
    AST_LEGACY: assert property (legacy_command_language && seconds_left == 12'h000 |=> seconds_left == 12'h000)
        else $error("countdown ran in legacy language");

    cover property ($rose(comms_timeout_fault));
    cover property ($fell(comms_timeout_fault));
    cover property (tmo_reject);
endmodule

//--- test/host_model.sv
/*
 * Host computer model: sends commands and watchdog enable writes.
 * Assumes the bench calls its tasks at a falling clock edge.
 */
`timescale 1ns/10ps
module host_model (
    // Clock
    input wire logic  clk,
    // Command side toward the watchdog
    output logic       cmd_rx_stb,
    output logic [1:0] cmd_rx_if,
    output logic       cmd_rx_web,
    output logic       host_wd_en_stb,
    output logic       host_wd_en_val
);
    initial begin
        cmd_rx_stb = 1'b0;
        cmd_rx_if = 2'h3;
        cmd_rx_web = 1'b0;
        host_wd_en_stb = 1'b0;
        host_wd_en_val = 1'b0;
    end
    // one command, qualifiers inverted once released
    task automatic send(input logic [1:0] ifc, input logic web);
        cmd_rx_stb = 1'b1;
        cmd_rx_if = ifc;
        cmd_rx_web = web;
        @(negedge clk);
        cmd_rx_stb = 1'b0;
        cmd_rx_if = ~ifc;
        cmd_rx_web = ~web;
    endtask
    task automatic write_en(input logic v);
        host_wd_en_stb = 1'b1;
        host_wd_en_val = v;
        @(negedge clk);
        host_wd_en_stb = 1'b0;
        host_wd_en_val = ~v;
    endtask
endmodule

//--- test/tb_comm_activity_watchdog.sv
/*
 * Self-checking bench for the communication activity watchdog.
 * Assumes a ten-cycle tick so one second lasts ten clocks.
 */
`timescale 1ns/10ps
module tb_comm_activity_watchdog;
    logic        clk = 1'b0, rst_b = 1'b0, host_tmo_stb = 1'b0, host_prot_clear = 1'b0;
    logic        legacy_command_language = 1'b0, power_switch_on = 1'b1;
    logic [4:0]  btn = 5'h00;
    logic [11:0] host_tmo_val = 12'h000, tmo;
    logic [1:0]  if_select = 2'h0, cmd_rx_if;
    logic [7:0]  unit_address = 8'h00, err_addr;
    logic        cmd_rx_stb, cmd_rx_web, host_wd_en_stb, host_wd_en_val, output_on, comms_timeout_fault;
    logic        alarm_led, fine_mode, wd_enabled, tmo_reject, err_push;
    logic [15:0] fault_cond, err_code;
    logic [11:0] watchdog_timeout_value, seconds_left;
    logic [23:0] exp_q[$];
    logic [23:0] e;
    int          err_count = 0, checks = 0, rej_cnt = 0;
    wire panel_out_btn = btn[0];
    wire panel_up_btn = btn[1];
    wire panel_down_btn = btn[2];
    wire panel_fine_btn = btn[3];
    wire panel_wd_toggle = btn[4];

    always #5 clk = ~clk;

    comm_activity_watchdog #(.CYCLES_PER_TICK(10)) comm_activity_watchdog_i (
        .clk(clk), .rst_b(rst_b), .cmd_rx_stb(cmd_rx_stb), .cmd_rx_if(cmd_rx_if), .cmd_rx_web(cmd_rx_web),
        .host_wd_en_stb(host_wd_en_stb), .host_wd_en_val(host_wd_en_val), .host_tmo_stb(host_tmo_stb),
        .host_tmo_val(host_tmo_val), .host_prot_clear(host_prot_clear), .if_select(if_select),
        .legacy_command_language(legacy_command_language), .unit_address(unit_address),
        .panel_wd_toggle(panel_wd_toggle), .panel_fine_btn(panel_fine_btn), .panel_up_btn(panel_up_btn),
        .panel_down_btn(panel_down_btn), .panel_out_btn(panel_out_btn), .power_switch_on(power_switch_on),
        .output_on(output_on), .comms_timeout_fault(comms_timeout_fault), .alarm_led(alarm_led),
        .fault_cond(fault_cond), .fine_mode(fine_mode), .wd_enabled(wd_enabled),
        .watchdog_timeout_value(watchdog_timeout_value), .seconds_left(seconds_left), .tmo_reject(tmo_reject),
        .err_push(err_push), .err_code(err_code), .err_addr(err_addr)
    );
    host_model host_model_i (
        .clk(clk), .cmd_rx_stb(cmd_rx_stb), .cmd_rx_if(cmd_rx_if), .cmd_rx_web(cmd_rx_web),
        .host_wd_en_stb(host_wd_en_stb), .host_wd_en_val(host_wd_en_val)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Synchroniser needs several clocks each way
    task automatic press(input int b);
        btn[b] = 1'b1;
        cyc(8);
        btn[b] = 1'b0;
        cyc(8);
    endtask
    task automatic wr_tmo(input logic [11:0] v);
        host_tmo_stb = 1'b1;
        host_tmo_val = v;
        cyc(1);
        host_tmo_stb = 1'b0;
        host_tmo_val = ~v;
        cyc(3);
    endtask
    task automatic expire;
        int n;
        n = 0;
        exp_q.push_back({16'h0156, unit_address});
        while (comms_timeout_fault !== 1'b1 && n < tmo * 10 + 30) begin
            cyc(1);
            n++;
        end
        if (n >= tmo * 10 + 30) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    // Result watcher: each error push takes the oldest note
    always @(negedge clk) begin
        if (tmo_reject === 1'b1)
            rej_cnt++;
        if (err_push === 1'b1) begin
            if (exp_q.size() == 0)
                check(1'b1, 1'b0);
            else begin
                e = exp_q.pop_front();
                check(err_code, e[23:8]);
                check(16'(err_addr), 16'(e[7:0]));
            end
        end
    end

    initial begin
        void'($urandom(32'hfd951f4c));
        // At least five seconds so two panel presses cannot reach expiry
        tmo = 12'(5 + $urandom % 4);
        unit_address = 8'($urandom);
        cyc(2);
        rst_b = 1'b1;
        cyc(1);
        check(16'(watchdog_timeout_value), 16'h0001);
        wr_tmo(12'h000);
        wr_tmo(12'he11);
        check(16'(rej_cnt), 16'h0002);
        wr_tmo(tmo);
        check(16'(watchdog_timeout_value), 16'(tmo));
        host_model_i.write_en(1'b1);
        cyc(1);
        check(wd_enabled, 1'b1);
        cyc(tmo * 10 + 30);
        check(comms_timeout_fault, 1'b0);
        host_model_i.send(2'h0, 1'b1);
        check(16'(seconds_left), 16'h0000);
        host_model_i.send(2'h1, 1'b0);
        check(16'(seconds_left), 16'h0000);
        press(0);
        check(output_on, 1'b1);
        host_model_i.send(2'h0, 1'b0);
        check(16'(seconds_left), 16'(tmo));
        press(3);
        press(3);
        check(16'(seconds_left == 12'h000), 16'h0000);
        check(fine_mode, 1'b0);
        expire();
        check(output_on, 1'b0);
        check(fault_cond, 16'h8000);
        check(alarm_led, 1'b1);
        press(0);
        check(output_on, 1'b0);
        host_prot_clear = 1'b1;
        cyc(1);
        host_prot_clear = 1'b0;
        cyc(1);
        check(fault_cond, 16'h0000);
        host_model_i.send(2'h0, 1'b0);
        wr_tmo(tmo);
        check(16'(seconds_left), 16'h0000);
        host_model_i.send(2'h0, 1'b0);
        if_select = 2'h1;
        cyc(2);
        check(16'(seconds_left), 16'h0000);
        host_model_i.send(2'h1, 1'b0);
        expire();
        power_switch_on = 1'b0;
        cyc(8);
        power_switch_on = 1'b1;
        check(comms_timeout_fault, 1'b0);
        host_model_i.send(2'h1, 1'b0);
        expire();
        host_model_i.write_en(1'b0);
        cyc(1);
        check(comms_timeout_fault, 1'b0);
        press(4);
        check(wd_enabled, 1'b1);
        press(1);
        check(16'(watchdog_timeout_value), 16'(tmo + 12'h00a));
        press(3);
        check(fine_mode, 1'b1);
        press(1);
        press(2);
        press(2);
        check(16'(watchdog_timeout_value), 16'(tmo + 12'h009));
        legacy_command_language = 1'b1;
        host_model_i.send(2'h1, 1'b0);
        cyc(2);
        check(16'(seconds_left), 16'h0000);
        check(16'(exp_q.size()), 16'h0000);
        tally_and_finish();
    end
endmodule

bind comm_activity_watchdog comm_activity_watchdog_assertions comm_activity_watchdog_assertions_i (
    .clk(clk), .rst_b(rst_b), .cmd_rx_stb(cmd_rx_stb), .cmd_rx_if(cmd_rx_if), .cmd_rx_web(cmd_rx_web),
    .host_wd_en_stb(host_wd_en_stb), .host_wd_en_val(host_wd_en_val), .host_tmo_stb(host_tmo_stb),
    .host_tmo_val(host_tmo_val), .host_prot_clear(host_prot_clear), .if_select(if_select),
    .legacy_command_language(legacy_command_language), .unit_address(unit_address), .output_on(output_on),
    .comms_timeout_fault(comms_timeout_fault), .fault_cond(fault_cond), .wd_enabled(wd_enabled),
    .watchdog_timeout_value(watchdog_timeout_value), .seconds_left(seconds_left), .tmo_reject(tmo_reject),
    .err_push(err_push), .err_code(err_code), .err_addr(err_addr)
);
